// ---- inc/ddr3_pins_pkg.sv ----
`default_nettype none
package ddr3_pins_pkg;
    // Pin widths
    localparam int DQ_W = 16;
    localparam int BYTE_W = 8;
    localparam int LANES = 2;
    localparam int BA_W = 3;
    localparam int ADDR_W = 14;
    localparam int CMD_W = 4;

    // Command codes on {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_MODE_LOAD = 4'h0;
    localparam logic [3:0] CMD_REFRESH = 4'h1;
    localparam logic [3:0] CMD_PRECHARGE = 4'h2;
    localparam logic [3:0] CMD_ACTIVATE = 4'h3;
    localparam logic [3:0] CMD_WRITE = 4'h4;
    localparam logic [3:0] CMD_READ = 4'h5;
    localparam logic [3:0] CMD_NOP = 4'h7;

    // Mode register holding the termination enable
    localparam logic [2:0] MR_TERM_SEL = 3'h1;
    localparam int MR_TERM_BIT = 2;
    localparam logic TERM_EN_RST = 1'b1;

    // Link edges from command to its data beat
    localparam int BEAT_LATENCY = 1;

    // Default storage depth in words
    localparam int MEM_DEPTH = 8;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WBEAT = 3'b010,
        ST_RBEAT = 3'b100
    } link_state_e;
endpackage
`default_nettype wire

// ---- core/pair_buffer.sv ----
`default_nettype none
module pair_buffer #(
    parameter int W = 18
) (
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Filling side
    input wire logic [W-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    // Draining side
    output logic [W-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    logic [W-1:0] tail_r;
    logic tail_v_r;
    logic push;
    logic pop;

    if (W < 1) begin : g_chk
        $error("pair_buffer: width must be at least one");
    end

    assign in_ready = !tail_v_r;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Head entry feeds the output
    always_ff @(posedge clock) begin
        if (srst) begin
            out_valid <= 1'b0;
            out_data <= '0;
        end else if (pop || !out_valid) begin
            if (tail_v_r) begin
                out_valid <= 1'b1;
                out_data <= tail_r;
            end else begin
                out_valid <= push;
                if (push) begin
                    out_data <= in_data;
                end
            end
        end
    end

    // Tail entry catches a word while the head stalls
    always_ff @(posedge clock) begin
        if (srst) begin
            tail_v_r <= 1'b0;
            tail_r <= '0;
        end else if (pop || !out_valid) begin
            tail_v_r <= 1'b0;
        end else if (push) begin
            tail_v_r <= 1'b1;
            tail_r <= in_data;
        end
    end
endmodule
`default_nettype wire

// ---- core/ddr3_pin_side.sv ----
// Behaviour
// R1 - Lower byte dropped when lower mask high
// R2 - Upper byte dropped when upper mask high
// R3 - Termination follows registered termination-control pin
// R4 - Termination only on data, strobes, masks
// R5 - Termination pin ignored once mode-disabled
// R6 - Command decoded from select, row, column, write
// R7 - Reset pin acts asynchronously, active low
// R8 - Lower byte carried on lower data lines
// R9 - Upper byte carried on upper data lines
// R10 - Lower strobe driven edge-aligned on reads
// R11 - Upper strobe driven edge-aligned on reads
// R12 - Deselected cycles never reach the decoder
// R13 - Inputs sampled on rising link clock
// R14 - Controller masks only bytes left unchanged
`default_nettype none
module ddr3_pin_side #(
    parameter int DEPTH = ddr3_pins_pkg::MEM_DEPTH
) (
    // Core clock and reset
    input wire logic clock,
    input wire logic srst,
    // Link clock and reset pin
    input wire logic ck,
    input wire logic reset_n,
    // Command and control pins
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic odt,
    input wire logic [ddr3_pins_pkg::BA_W-1:0] ba,
    input wire logic [ddr3_pins_pkg::ADDR_W-1:0] addr,
    // Data lanes
    input wire logic [ddr3_pins_pkg::DQ_W-1:0] dq_in,
    output logic [ddr3_pins_pkg::DQ_W-1:0] dq_out,
    output logic [ddr3_pins_pkg::LANES-1:0] dq_oe_n,
    input wire logic ldm,
    input wire logic udm,
    // Byte strobes
    input wire logic ldqs_in,
    output logic ldqs_out,
    output logic ldqs_oe_n,
    input wire logic udqs_in,
    output logic udqs_out,
    output logic udqs_oe_n,
    // Termination on the data group pads
    output logic term_on,
    // Written words towards the core
    output logic [ddr3_pins_pkg::DQ_W-1:0] wr_word,
    output logic [ddr3_pins_pkg::LANES-1:0] wr_keep,
    output logic wr_valid,
    input wire logic wr_ready,
    output logic overrun
);
    import ddr3_pins_pkg::*;

    localparam int COL_W = $clog2(DEPTH);
    localparam int XW = DQ_W + LANES;

    if (DEPTH < 2 || DEPTH > (1 << ADDR_W) ||
        (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
        $error("ddr3_pin_side: DEPTH must be a power of two");
    end

    function automatic logic [DQ_W-1:0] merge(
        input logic [DQ_W-1:0] old_w,
        input logic [DQ_W-1:0] new_w,
        input logic [LANES-1:0] keep
    );
        logic [DQ_W-1:0] res;
        res = old_w;
        for (int i = 0; i < LANES; i++) begin
            if (keep[i]) begin
                res[i*BYTE_W +: BYTE_W] = new_w[i*BYTE_W +: BYTE_W];
            end
        end
        return res;
    endfunction

    // Link domain
    link_state_e st_r;
    logic [DQ_W-1:0] mem_r [DEPTH];
    logic [COL_W-1:0] col_r;
    logic term_en_r;
    logic [DQ_W-1:0] xfer_word_r;
    logic [LANES-1:0] xfer_keep_r;
    logic req_tgl_r;
    logic ack_s1_r;
    logic ack_s2_r;
    logic ack_tgl_r;
    logic [CMD_W-1:0] cmd;
    logic sel;
    logic busy;
    logic [LANES-1:0] beat_keep;
    logic [DQ_W-1:0] col_word;
    logic [DQ_W-1:0] addr_word;

    assign cmd = {cs_n, ras_n, cas_n, we_n}; // [R6]
    assign sel = !cs_n && st_r == ST_IDLE; // [R12]
    assign busy = req_tgl_r != ack_s2_r;
    assign beat_keep = {!udm, !ldm}; // [R1] [R2]
    assign col_word = mem_r[col_r];
    assign addr_word = mem_r[addr[COL_W-1:0]];

    // Command sequencer, sampled on rising ck
    always_ff @(posedge ck or negedge reset_n) begin // [R7] [R13]
        if (!reset_n) begin
            st_r <= ST_IDLE;
            col_r <= '0;
        end else begin
            case (st_r)
                ST_IDLE: begin
                    if (sel && cmd == CMD_WRITE) begin // [R6]
                        st_r <= ST_WBEAT;
                        col_r <= addr[COL_W-1:0];
                    end else if (sel && cmd == CMD_READ) begin
                        st_r <= ST_RBEAT;
                        col_r <= addr[COL_W-1:0];
                    end
                end
                ST_WBEAT: st_r <= ST_IDLE;
                ST_RBEAT: st_r <= ST_IDLE;
                default: st_r <= ST_IDLE;
            endcase
        end
    end

    // Storage with byte masking
    always_ff @(posedge ck or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= '0;
            end
        end else if (st_r == ST_WBEAT) begin
            mem_r[col_r] <= merge(col_word, dq_in, beat_keep); // [R1] [R2]
        end
    end

    // Termination enable from mode load
    always_ff @(posedge ck or negedge reset_n) begin
        if (!reset_n) begin
            term_en_r <= TERM_EN_RST;
        end else if (sel && cmd == CMD_MODE_LOAD && ba == MR_TERM_SEL) begin
            term_en_r <= addr[MR_TERM_BIT]; // [R5]
        end
    end

    // Termination applied only to the data group pads
    always_ff @(posedge ck or negedge reset_n) begin
        if (!reset_n) begin
            term_on <= 1'b0;
        end else begin
            term_on <= odt && term_en_r; // [R3] [R4] [R5]
        end
    end

    // Read beat drives both lanes and strobes
    always_ff @(posedge ck or negedge reset_n) begin
        if (!reset_n) begin
            dq_out <= '0;
            dq_oe_n <= '1;
            ldqs_out <= 1'b0;
            ldqs_oe_n <= 1'b1;
            udqs_out <= 1'b0;
            udqs_oe_n <= 1'b1;
        end else if (sel && cmd == CMD_READ) begin
            dq_out[BYTE_W-1:0] <= addr_word[BYTE_W-1:0]; // [R8]
            dq_out[DQ_W-1:BYTE_W] <= addr_word[DQ_W-1:BYTE_W]; // [R9]
            dq_oe_n <= '0;
            ldqs_out <= 1'b1; // [R10]
            ldqs_oe_n <= 1'b0;
            udqs_out <= 1'b1; // [R11]
            udqs_oe_n <= 1'b0;
        end else begin
            dq_oe_n <= '1;
            ldqs_out <= 1'b0;
            ldqs_oe_n <= 1'b1;
            udqs_out <= 1'b0;
            udqs_oe_n <= 1'b1;
        end
    end

    // Written beat launched towards the core
    always_ff @(posedge ck or negedge reset_n) begin
        if (!reset_n) begin
            xfer_word_r <= '0;
            xfer_keep_r <= '0;
            req_tgl_r <= 1'b0;
            overrun <= 1'b0;
        end else if (st_r == ST_WBEAT) begin
            if (busy) begin
                overrun <= 1'b1;
            end else begin
                xfer_word_r <= dq_in;
                xfer_keep_r <= beat_keep; // [R1] [R2]
                req_tgl_r <= !req_tgl_r;
            end
        end
    end

    // Acknowledge toggle into the link domain
    always_ff @(posedge ck or negedge reset_n) begin
        if (!reset_n) begin
            ack_s1_r <= 1'b0;
            ack_s2_r <= 1'b0;
        end else begin
            ack_s1_r <= ack_tgl_r;
            ack_s2_r <= ack_s1_r;
        end
    end

    // Core domain
    logic req_s1_r;
    logic req_s2_r;
    logic buf_in_ready;
    logic take;

    assign take = req_s2_r != ack_tgl_r && buf_in_ready;

    always_ff @(posedge clock) begin
        if (srst) begin
            req_s1_r <= 1'b0;
            req_s2_r <= 1'b0;
        end else begin
            req_s1_r <= req_tgl_r;
            req_s2_r <= req_s1_r;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            ack_tgl_r <= 1'b0;
        end else if (take) begin
            ack_tgl_r <= req_s2_r;
        end
    end

    pair_buffer #(
        .W(XW)
    ) u_buf (
        .clock(clock),
        .srst(srst),
        .in_data({xfer_keep_r, xfer_word_r}),
        .in_valid(req_s2_r != ack_tgl_r),
        .in_ready(buf_in_ready),
        .out_data({wr_keep, wr_word}),
        .out_valid(wr_valid),
        .out_ready(wr_ready)
    );

    // Checks
    sequence s_read_cmd;
        !cs_n && cmd == CMD_READ && st_r == ST_IDLE;
    endsequence

    sequence s_low_strobe_beat;
        ldqs_out && !ldqs_oe_n && !dq_oe_n[0] ##1 ldqs_oe_n && dq_oe_n[0];
    endsequence

    sequence s_up_strobe_beat;
        udqs_out && !udqs_oe_n && !dq_oe_n[1] ##1 udqs_oe_n && dq_oe_n[1];
    endsequence

    sequence s_term_off_load;
        !cs_n && cmd == CMD_MODE_LOAD && st_r == ST_IDLE &&
            ba == MR_TERM_SEL && !addr[MR_TERM_BIT];
    endsequence

    chk_lower_mask_drop: assert property ( // [R1]
        @(posedge ck) disable iff (!reset_n)
        st_r == ST_WBEAT && ldm |=>
            col_word[BYTE_W-1:0] == $past(col_word[BYTE_W-1:0]))
        else $error("lower byte written while masked");

    chk_upper_mask_drop: assert property ( // [R2]
        @(posedge ck) disable iff (!reset_n)
        st_r == ST_WBEAT && udm |=>
            col_word[DQ_W-1:BYTE_W] == $past(col_word[DQ_W-1:BYTE_W]))
        else $error("upper byte written while masked");

    chk_term_follow: assert property ( // [R3]
        @(posedge ck) disable iff (!reset_n)
        term_en_r |=> term_on == $past(odt))
        else $error("termination does not follow its pin");

    chk_term_off_ignore: assert property ( // [R5]
        @(posedge ck) disable iff (!reset_n)
        s_term_off_load ##1 !(!cs_n && cmd == CMD_MODE_LOAD)
            |=> !term_on [*2])
        else $error("termination pin not ignored after disable");

    chk_deselect_idle: assert property ( // [R12]
        @(posedge ck) disable iff (!reset_n)
        st_r == ST_IDLE && cs_n |=> st_r == ST_IDLE && dq_oe_n == '1)
        else $error("deselected command was acted on");

    chk_write_decode: assert property ( // [R6]
        @(posedge ck) disable iff (!reset_n)
        st_r == ST_IDLE && !cs_n && ras_n && !cas_n && !we_n |=>
            st_r == ST_WBEAT ##1 st_r == ST_IDLE)
        else $error("write command not decoded");

    chk_low_strobe: assert property ( // [R10]
        @(posedge ck) disable iff (!reset_n)
        s_read_cmd |=> s_low_strobe_beat)
        else $error("lower strobe not driven with read beat");

    chk_up_strobe: assert property ( // [R11]
        @(posedge ck) disable iff (!reset_n)
        s_read_cmd |=> s_up_strobe_beat)
        else $error("upper strobe not driven with read beat");

    chk_lane_bytes: assert property ( // [R8] [R9]
        @(posedge ck) disable iff (!reset_n)
        s_read_cmd |=> dq_out == $past(addr_word))
        else $error("read bytes on wrong lanes");

    chk_no_lost_word: assert property (
        @(posedge clock) disable iff (srst)
        wr_valid && !wr_ready |=> wr_valid && $stable(wr_word))
        else $error("stalled word changed or dropped");
endmodule
`default_nettype wire

// ---- sim/ctrl_model.sv ----
`default_nettype none
module ctrl_model (
    // Link clock and reset pin
    output logic ck,
    output logic reset_n,
    // Command and control pins
    output logic cs_n,
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output logic odt,
    output logic [2:0] ba,
    output logic [13:0] addr,
    // Write side of the data group
    output logic [15:0] c_dq,
    output logic ldm,
    output logic udm,
    output logic c_dqs,
    // Read side of the data group
    input wire logic [15:0] dq_out,
    input wire logic [1:0] dq_oe_n,
    input wire logic ldqs_out,
    input wire logic udqs_out,
    input wire logic ldqs_oe_n,
    input wire logic udqs_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [15:0] got_q;
    logic [1:0] got_oe;
    logic [3:0] got_s;

    // Free-running link clock, phase unrelated to the core clock
    initial begin
        ck = 1'b0;
        #3;
        forever #16 ck = ~ck;
    end

    initial begin
        reset_n = 1'b0;
        {cs_n, ras_n, cas_n, we_n} = 4'hF;
        {odt, ba, addr} = '0;
        {c_dq, udm, ldm, c_dqs} = '0;
    end

    // One command, then its beat; read data captured at the beat edge
    task automatic op(input logic [3:0] c, input logic [2:0] b,
        input logic [13:0] a, input logic [15:0] d, input logic [1:0] m);
        @(posedge ck);
        {cs_n, ras_n, cas_n, we_n} <= c;
        ba <= b;
        addr <= a;
        @(posedge ck);
        {cs_n, ras_n, cas_n, we_n} <= 4'hF;
        c_dq <= d;
        {udm, ldm} <= m;
        c_dqs <= 1'b1;
        @(posedge ck);
        got_q = dq_out;
        got_oe = dq_oe_n;
        got_s = {ldqs_out, udqs_out, ldqs_oe_n, udqs_oe_n};
        c_dq <= ~d;
        {udm, ldm} <= ~m;
        c_dqs <= 1'b0;
    endtask

    task automatic set_odt(input logic v);
        @(posedge ck);
        odt <= v;
        @(posedge ck);
    endtask

    // Reset pin moved away from any link edge
    task automatic hold_reset(input logic v);
        @(posedge ck);
        #7;
        reset_n = v;
    endtask
endmodule
`default_nettype wire

// ---- sim/ddr3_pin_side_test.sv ----
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module ddr3_pin_side_test;
    timeunit 1ns;
    timeprecision 1ps;
    import ddr3_pins_pkg::*;

    typedef struct packed {
        logic [13:0] a;
        logic [15:0] d0;
        logic [15:0] d1;
        logic [1:0] m;
        logic [15:0] q;
    } row_s;
    row_s rows [5] = '{
        '{14'h1, 16'h1111, 16'hAAAA, 2'h0, 16'hAAAA},
        '{14'h2, 16'h2222, 16'hBBBB, 2'h1, 16'hBB22},
        '{14'h3, 16'h3333, 16'hCCCC, 2'h2, 16'h33CC},
        '{14'h4, 16'h4444, 16'hDDDD, 2'h3, 16'h4444},
        '{14'h1F07, 16'h5A5A, 16'h0F0F, 2'h0, 16'h0F0F}};

    int n_errors = 0;
    int n_checks = 0;
    logic clock, srst, wr_ready;
    logic ck, reset_n, cs_n, ras_n, cas_n, we_n, odt, ldm, udm, c_dqs;
    logic [2:0] ba;
    logic [13:0] addr;
    logic [15:0] c_dq, dq_in, dq_out, wr_word;
    logic [1:0] dq_oe_n, wr_keep;
    logic ldqs_in, ldqs_out, ldqs_oe_n, udqs_in, udqs_out, udqs_oe_n;
    logic term_on, wr_valid, overrun;

    // Wire level of each shared pin from the pin side's output enables
    assign dq_in[7:0] = dq_oe_n[0] ? c_dq[7:0] : dq_out[7:0];
    assign dq_in[15:8] = dq_oe_n[1] ? c_dq[15:8] : dq_out[15:8];
    assign ldqs_in = ldqs_oe_n ? c_dqs : ldqs_out;
    assign udqs_in = udqs_oe_n ? c_dqs : udqs_out;

    ddr3_pin_side #(.DEPTH(8)) i_ddr3_pin_side (
        .clock(clock), .srst(srst), .ck(ck), .reset_n(reset_n),
        .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
        .odt(odt), .ba(ba), .addr(addr), .dq_in(dq_in), .dq_out(dq_out),
        .dq_oe_n(dq_oe_n), .ldm(ldm), .udm(udm), .ldqs_in(ldqs_in),
        .ldqs_out(ldqs_out), .ldqs_oe_n(ldqs_oe_n), .udqs_in(udqs_in),
        .udqs_out(udqs_out), .udqs_oe_n(udqs_oe_n), .term_on(term_on),
        .wr_word(wr_word), .wr_keep(wr_keep), .wr_valid(wr_valid),
        .wr_ready(wr_ready), .overrun(overrun));

    ctrl_model i_ctrl_model (
        .ck(ck), .reset_n(reset_n), .cs_n(cs_n), .ras_n(ras_n),
        .cas_n(cas_n), .we_n(we_n), .odt(odt), .ba(ba), .addr(addr),
        .c_dq(c_dq), .ldm(ldm), .udm(udm), .c_dqs(c_dqs),
        .dq_out(dq_out), .dq_oe_n(dq_oe_n), .ldqs_out(ldqs_out),
        .udqs_out(udqs_out), .ldqs_oe_n(ldqs_oe_n),
        .udqs_oe_n(udqs_oe_n));

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    task automatic final_report();
        $display("errors %0d checks %0d", n_errors, n_checks);
        if (n_errors == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic wait_valid();
        for (int i = 0; i < 40; i++) begin
            @(negedge clock);
            if (wr_valid === 1'b1) return;
        end
        n_errors++;
        $display("CHECK FAILED wr_valid exp 1 got 0");
        final_report();
    endtask

    task automatic wr(input logic [13:0] a, input logic [15:0] d,
        input logic [1:0] m);
        logic [15:0] k;
        k = {{8{~m[1]}}, {8{~m[0]}}};
        i_ctrl_model.op(CMD_WRITE, a[2:0], a, d, m);
        wait_valid();
        `CHK("wr_keep", ~m, wr_keep)
        `CHK("wr_word", d & k, wr_word & k)
    endtask

    task automatic rd(input logic [13:0] a, input logic [15:0] q);
        i_ctrl_model.op(CMD_READ, a[2:0], a, ~q, 2'h3);
        `CHK("dq_out", q, i_ctrl_model.got_q)
        `CHK("dq_oe_n", 2'h0, i_ctrl_model.got_oe)
        `CHK("strobes", 4'hC, i_ctrl_model.got_s)
        #1;
        `CHK("dq_oe_n idle", 2'h3, dq_oe_n)
    endtask

    initial begin
        srst = 1'b1;
        wr_ready = 1'b1;
        repeat (16) @(posedge clock);
        srst <= 1'b0;
        i_ctrl_model.hold_reset(1'b1);
        #1;
        `CHK("dq_oe_n rst", 2'h3, dq_oe_n)
        `CHK("term_on rst", 1'b0, term_on)
        `CHK("wr_valid rst", 1'b0, wr_valid)
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d0, 2'h0);
            wr(rows[i].a, rows[i].d1, rows[i].m);
            rd(rows[i].a, rows[i].q);
        end
        // Deselected read
        i_ctrl_model.op(4'hD, 3'h0, 14'h1, 16'h0, 2'h0);
        `CHK("cs_n high", 2'h3, i_ctrl_model.got_oe)
        // Termination control and mode disable
        i_ctrl_model.set_odt(1'b1);
        #1;
        `CHK("term_on odt", 1'b1, term_on)
        // Mode load to another register leaves termination alone
        i_ctrl_model.op(CMD_MODE_LOAD, 3'h2, 14'h0, 16'h0, 2'h0);
        #1;
        `CHK("term_on other mr", 1'b1, term_on)
        i_ctrl_model.op(CMD_MODE_LOAD, 3'h1, 14'h0, 16'h0, 2'h0);
        #1;
        `CHK("term_on off", 1'b0, term_on)
        i_ctrl_model.op(CMD_MODE_LOAD, 3'h1, 14'h4, 16'h0, 2'h0);
        #1;
        `CHK("term_on back", 1'b1, term_on)
        i_ctrl_model.set_odt(1'b0);
        #1;
        `CHK("term_on low", 1'b0, term_on)
        // Stalled consumer
        @(posedge clock);
        wr_ready <= 1'b0;
        for (logic [15:0] v = 16'h5000; v < 16'h5005; v++) begin
            i_ctrl_model.op(CMD_WRITE, 3'h0, 14'h0, v, 2'h0);
        end
        `CHK("overrun", 1'b1, overrun)
        @(posedge clock);
        wr_ready <= 1'b1;
        wait_valid();
        `CHK("first word", 16'h5000, wr_word)
        repeat (20) @(posedge clock);
        `CHK("drained", 1'b0, wr_valid)
        rd(14'h0, 16'h5004);
        // Reset pin between link edges
        i_ctrl_model.set_odt(1'b1);
        i_ctrl_model.hold_reset(1'b0);
        #1;
        `CHK("overrun rst", 1'b0, overrun)
        `CHK("term_on rst2", 1'b0, term_on)
        @(posedge clock);
        srst <= 1'b1;
        repeat (3) @(posedge clock);
        srst <= 1'b0;
        i_ctrl_model.hold_reset(1'b1);
        rd(14'h1, 16'h0);
        final_report();
    end
endmodule
`default_nettype wire
